// ---- rtl/byte_bus_pkg.sv ----
// constants for the byte-wide bus cycle sequencer
`default_nettype none
package byte_bus_pkg;
  localparam int ADDR_W        = 20;
  localparam int DATA_W        = 8;
  localparam int SPACE_W       = 3;
  // transfer sizes on the request port
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  // byte cycles per size
  localparam logic [2:0] BYTES_BYTE = 3'h1;
  localparam logic [2:0] BYTES_WORD = 3'h2;
  localparam logic [2:0] BYTES_LONG = 3'h4;
  // internal modify time of a read-modify-write, in half clocks (S8..S11)
  localparam logic [2:0] RMW_HOLD_HALVES = 3'h4;
  // each bus state is one half clock of the processor clock; one mclk cycle per state
  localparam int MCLK_PERIOD_NS = 10;
endpackage
`default_nettype wire

// ---- rtl/byte_bus_cycle_master.sv ----
// byte-wide asynchronous bus cycle sequencer: read, write and read-modify-write
`default_nettype none
module byte_bus_cycle_master
  import byte_bus_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic               i_mclk,                 // state clock, one tick per bus state
  input  wire logic               i_rst,                  // synchronous reset, active high
  input  wire logic               i_req,                  // start a transfer (level, taken when idle)
  input  wire logic               i_write,                // 1 write, 0 read
  input  wire logic               i_atomic_test_set_op,   // read-modify-write of one byte
  input  wire logic [1:0]         i_size,                 // byte, word or long
  input  wire logic [AW-1:0]      i_addr,                 // first byte address
  input  wire logic [SPACE_W-1:0] i_space_code,           // address space code
  input  wire logic [31:0]        i_wdata,                // write data, most significant byte first
  input  wire logic               i_transfer_ack_n,       // pin: acknowledge
  input  wire logic               i_bus_fault_n,          // pin: bus fault
  input  wire logic               i_legacy_periph_sel_n,  // pin: legacy peripheral select
  input  wire logic [DATA_W-1:0]  i_data,                 // pin: data bus in
  output logic                    o_busy,                 // sequencer not idle
  output logic                    o_done,                 // transfer complete pulse
  output logic                    o_fault,                // with o_done: ended by bus fault
  output logic                    o_legacy,               // with o_done: diverted to legacy cycle
  output logic [31:0]             o_rdata,                // read data, right aligned
  output logic [AW-1:0]           o_addr,                 // pin: address bus
  output logic                    o_addr_oe,              // address bus driven
  output logic [SPACE_W-1:0]      o_space_code,           // pin: space code
  output logic                    o_space_oe,             // space code driven
  output logic                    o_rw,                   // pin: read high, write low
  output logic                    o_addr_strobe_n,        // pin: address strobe
  output logic                    o_lower_byte_strobe_n,  // pin: lower byte strobe
  output logic                    o_data_strobe_n,        // pin: data strobe
  output logic                    o_upper_byte_strobe_n,  // pin: upper byte strobe
  output logic [15:0]             o_data,                 // pin: data bus out
  output logic                    o_data_oe               // data bus driven
);

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RD   = 7'h02,
    ST_WR   = 7'h04,
    ST_MOD  = 7'h08,
    ST_RMWW = 7'h10,
    ST_TAIL = 7'h20,
    ST_END  = 7'h40
  } phase_e;

  phase_e              phase_q;
  logic [2:0]          st_q;          // state inside a half cycle: 0..7
  logic [2:0]          left_q;        // byte cycles still to run
  logic [AW-1:0]       addr_q;
  logic [31:0]         wdata_q;
  logic [31:0]         rdata_q;
  logic                rmw_q;
  logic                wr_q;
  logic                fault_q;
  logic                legacy_q;
  logic [2:0]          mod_q;
  logic                ack_s1_q, ack_s2_q, ack_s3_q;
  logic                flt_s1_q, flt_s2_q, flt_s3_q;
  logic                sel_s1_q, sel_s2_q, sel_s3_q;
  logic                ack_q, flt_q, sel_q;
  logic                armed_q;       // terminator released since this byte began

  // three-stage synchronisers; a level counts once stages two and three agree
  // the pins are asynchronous to i_mclk; the price is about four clocks of latency
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      {ack_s1_q, ack_s2_q, ack_s3_q, ack_q} <= 4'hF;
      {flt_s1_q, flt_s2_q, flt_s3_q, flt_q} <= 4'hF;
      {sel_s1_q, sel_s2_q, sel_s3_q, sel_q} <= 4'hF;
    end else begin
      {ack_s1_q, ack_s2_q, ack_s3_q} <= {i_transfer_ack_n, ack_s1_q, ack_s2_q};
      {flt_s1_q, flt_s2_q, flt_s3_q} <= {i_bus_fault_n, flt_s1_q, flt_s2_q};
      {sel_s1_q, sel_s2_q, sel_s3_q} <= {i_legacy_periph_sel_n, sel_s1_q, sel_s2_q};
      if (ack_s2_q == ack_s3_q) ack_q <= ack_s3_q;
      if (flt_s2_q == flt_s3_q) flt_q <= flt_s3_q;
      if (sel_s2_q == sel_s3_q) sel_q <= sel_s3_q;
    end
  end

  logic active;
  logic wait_st;     // S4 or a wait state, on an even/falling boundary
  logic term;
  assign active  = (phase_q == ST_RD) || (phase_q == ST_WR) || (phase_q == ST_RMWW);
  assign wait_st = active && (st_q == 3'h4);
  assign term    = !ack_q || !flt_q || !sel_q;

  // the synchronised terminators lag the pins, so the previous byte's terminator
  // would still look valid at the next S4; a byte may only end after its
  // terminator has first been seen released (release wins over a same-cycle clear)
  always_ff @(posedge i_mclk) begin
    if (i_rst) armed_q <= 1'b0;
    else if (!term) armed_q <= 1'b1;
    else if ((phase_q == ST_IDLE && i_req) || (active && st_q == 3'h7)) armed_q <= 1'b0;
  end

  // state sequencing; st_q stands in S4 until a terminator is seen
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      phase_q  <= ST_IDLE;
      st_q     <= 3'h0;
      left_q   <= 3'h0;
      mod_q    <= 3'h0;
      fault_q  <= 1'b0;
      legacy_q <= 1'b0;
    end else begin
      unique case (phase_q)
        ST_IDLE: begin
          fault_q  <= 1'b0;
          legacy_q <= 1'b0;
          st_q     <= 3'h0;
          if (i_req) begin
            phase_q <= i_write && !i_atomic_test_set_op ? ST_WR : ST_RD;
            if (i_atomic_test_set_op || i_size == SIZE_BYTE) left_q <= BYTES_BYTE;
            else if (i_size == SIZE_WORD) left_q <= BYTES_WORD;
            else left_q <= BYTES_LONG;
          end
        end
        ST_RD, ST_WR, ST_RMWW: begin
          // a stale terminator left from the previous byte does not count
          if (wait_st && !(term && armed_q)) st_q <= st_q;
          else if (wait_st && !sel_q && ack_q && flt_q) begin
            // strobes drop in the tail's last state so done never sees them low
            legacy_q <= 1'b1;
            st_q     <= 3'h6;
            phase_q  <= ST_TAIL;
          end else if (wait_st && !flt_q && ack_q) begin
            fault_q  <= 1'b1;
            phase_q  <= ST_TAIL;
          end else if (st_q == 3'h7) begin
            st_q   <= 3'h0;
            left_q <= left_q - 3'h1;
            if (rmw_q && phase_q == ST_RD) begin
              phase_q <= ST_MOD;
              mod_q   <= 3'h0;
            end else if (left_q == 3'h1) phase_q <= ST_END;
          end else st_q <= st_q + 3'h1;
        end
        ST_MOD: begin
          // S8..S11, then S12 and S13 are the first two of the write half
          mod_q <= mod_q + 3'h1;
          if (mod_q == RMW_HOLD_HALVES - 3'h1) begin
            phase_q <= ST_RMWW;
            st_q    <= 3'h0;
            left_q  <= BYTES_BYTE;
          end
        end
        ST_TAIL: begin
          st_q <= st_q + 3'h1;
          if (st_q == 3'h6) phase_q <= ST_END;
        end
        ST_END: phase_q <= ST_IDLE;
        default: phase_q <= ST_IDLE;
      endcase
    end
  end

  // request capture and address stepping; A0 goes out with each byte
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      addr_q  <= '0;
      wdata_q <= 32'h0;
      rmw_q   <= 1'b0;
      wr_q    <= 1'b0;
    end else if (phase_q == ST_IDLE && i_req) begin
      addr_q  <= i_addr;
      rmw_q   <= i_atomic_test_set_op;
      wr_q    <= i_write && !i_atomic_test_set_op;
      if (i_size == SIZE_LONG) wdata_q <= i_wdata;
      else if (i_size == SIZE_WORD) wdata_q <= {i_wdata[15:0], 16'h0};
      else wdata_q <= {i_wdata[7:0], 24'h0};
    end else if (active && st_q == 3'h7 && !rmw_q) begin
      addr_q  <= addr_q + AW'(1);
      wdata_q <= {wdata_q[23:0], 8'h0};
    end
  end

  // read data captured as the S6/S7 boundary passes
  always_ff @(posedge i_mclk) begin
    if (i_rst) rdata_q <= 32'h0;
    else if (phase_q == ST_IDLE && i_req) rdata_q <= 32'h0;
    else if ((phase_q == ST_RD) && st_q == 3'h6 && term) rdata_q <= {rdata_q[23:0], i_data};
  end

  // bus pin drivers, registered from the current state
  logic as_on, ds_on, rw_low, d_on, a_on, fc_on;
  always_comb begin
    as_on  = 1'b0;
    ds_on  = 1'b0;
    rw_low = 1'b0;
    d_on   = 1'b0;
    a_on   = 1'b0;
    fc_on  = 1'b0;
    unique case (phase_q)
      ST_RD: begin
        fc_on = 1'b1;
        a_on  = st_q >= 3'h1;
        as_on = st_q >= 3'h2 && st_q <= 3'h6;
        ds_on = as_on;
        if (rmw_q && st_q >= 3'h2) as_on = 1'b1;
      end
      ST_WR: begin
        fc_on  = 1'b1;
        a_on   = st_q >= 3'h1;
        as_on  = st_q >= 3'h2 && st_q <= 3'h6;
        rw_low = st_q >= 3'h2;
        d_on   = st_q >= 3'h3;
        ds_on  = st_q >= 3'h4 && st_q <= 3'h6;
      end
      ST_MOD: begin
        fc_on = 1'b1;
        a_on  = 1'b1;
        as_on = 1'b1;
      end
      ST_RMWW: begin
        // st_q 0..7 stand for S12..S19
        fc_on  = 1'b1;
        a_on   = 1'b1;
        as_on  = st_q <= 3'h6;
        rw_low = st_q >= 3'h2;
        d_on   = st_q >= 3'h3;
        ds_on  = st_q >= 3'h4 && st_q <= 3'h6;
      end
      ST_TAIL: begin
        // faulted cycle runs three more states with strobes off; a legacy diversion
        // enters at the last one only
        fc_on  = 1'b1;
        a_on   = st_q <= 3'h5;
        rw_low = wr_q && st_q <= 3'h5;
        d_on   = wr_q && st_q <= 3'h5;
      end
      ST_IDLE, ST_END: begin
        as_on = 1'b0;
      end
      default: as_on = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_addr_strobe_n       <= 1'b1;
      o_lower_byte_strobe_n <= 1'b1;
      o_data_strobe_n       <= 1'b1;
      o_rw                  <= 1'b1;
      o_addr_oe             <= 1'b0;
      o_space_oe            <= 1'b0;
      o_data_oe             <= 1'b0;
      o_addr                <= '0;
      o_space_code          <= '0;
      o_data                <= 16'h0;
    end else begin
      o_addr_strobe_n       <= !as_on;
      o_lower_byte_strobe_n <= !ds_on;
      o_data_strobe_n       <= !ds_on;
      o_rw                  <= !rw_low;
      o_addr_oe             <= a_on;
      o_space_oe            <= fc_on;
      o_data_oe             <= d_on;
      o_addr                <= addr_q;
      if (phase_q == ST_IDLE && i_req) o_space_code <= i_space_code;
      // upper lines carry nothing meaningful in byte mode
      o_data                <= {8'h00, rmw_q ? (rdata_q[7:0] | 8'h80) : wdata_q[31:24]};
    end
  end

  // the modify step of test-and-set sets the top bit of the byte read
  assign o_upper_byte_strobe_n = 1'b1;
  assign o_busy   = phase_q != ST_IDLE;
  assign o_done   = phase_q == ST_END;
  assign o_fault  = fault_q;
  assign o_legacy = legacy_q;
  assign o_rdata  = rdata_q;

endmodule
`default_nettype wire

// ---- test/byte_bus_props.sv ----
// concurrent checks on the pins of the byte bus sequencer
`default_nettype none
module byte_bus_props #(
  parameter int AW = 20
) (
  input wire logic          i_mclk,                 // clock
  input wire logic          i_rst,                  // reset
  input wire logic          i_transfer_ack_n,       // ack pin
  input wire logic          i_bus_fault_n,          // fault pin
  input wire logic          i_legacy_periph_sel_n,  // legacy pin
  input wire logic          o_done,                 // done
  input wire logic          o_fault,                // fault
  input wire logic [AW-1:0] o_addr,                 // address
  input wire logic          o_addr_oe,              // addr enable
  input wire logic [2:0]    o_space_code,           // space
  input wire logic          o_space_oe,             // space enable
  input wire logic          o_rw,                   // read/write
  input wire logic          o_addr_strobe_n,        // addr strobe
  input wire logic          o_lower_byte_strobe_n,  // lower strobe
  input wire logic          o_data_strobe_n,        // data strobe
  input wire logic          o_upper_byte_strobe_n,  // upper strobe
  input wire logic          o_data_oe               // data enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic no_term;
  assign no_term = i_transfer_ack_n && i_bus_fault_n && i_legacy_periph_sel_n;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  AST_UPPER_NEGATED: assert property (o_upper_byte_strobe_n)
    else $error("upper strobe asserted");
  AST_LOWER_TRACKS: assert property (o_lower_byte_strobe_n == o_data_strobe_n)
    else $error("lower strobe differs from data strobe");
  AST_ADDR_WITH_AS: assert property (!o_addr_strobe_n |-> o_addr_oe && o_space_oe)
    else $error("strobe without address or space code");
  AST_DS_INSIDE_AS: assert property (!o_data_strobe_n |-> !o_addr_strobe_n)
    else $error("data strobe outside address strobe");
  AST_READ_STROBES: assert property ($fell(o_addr_strobe_n) && o_rw |-> !o_data_strobe_n)
    else $error("read strobes not together");
  AST_WRITE_AS_FIRST: assert property ($fell(o_addr_strobe_n) && !o_rw |->
    o_data_strobe_n ##1 o_data_strobe_n) else $error("write data strobe too early");
  AST_DATA_BEFORE_DS: assert property ($fell(o_data_strobe_n) && !o_rw |->
    o_data_oe && $past(o_data_oe)) else $error("write strobe before data");
  AST_DATA_OE_WRITE: assert property (o_data_oe |-> !o_rw)
    else $error("data driven while reading");
  AST_WAIT_STATES: assert property ((!o_data_strobe_n && no_term) [*6] |=>
    !o_data_strobe_n) else $error("cycle ended without terminator");
  AST_ADDR_STABLE: assert property (!o_addr_strobe_n && !$past(o_addr_strobe_n) |->
    $stable(o_addr) && $stable(o_space_code)) else $error("address moved under strobe");
  AST_DONE_RELEASED: assert property (o_done |-> o_addr_strobe_n && o_data_strobe_n)
    else $error("done with strobes held");
  COV_FAULT: cover property (o_done && o_fault);
  COV_NORMAL: cover property (o_done && !o_fault);
  COV_RMW_WRITE: cover property ($fell(o_rw) && !$past(o_addr_strobe_n));
endmodule
bind byte_bus_cycle_master byte_bus_props #(.AW(AW)) i_props (.*);
`default_nettype wire

// ---- test/byte_bus_slave_model.sv ----
// behavioural byte-wide slave: memory, wait states, fault and legacy replies
`default_nettype none
module byte_bus_slave_model (
  input  wire logic        i_mclk,   // clock
  input  wire logic        i_rst,    // reset
  input  wire logic        i_as_n,   // addr strobe
  input  wire logic        i_ds_n,   // data strobe
  input  wire logic        i_rw,     // read/write
  input  wire logic [19:0] i_addr,   // address
  input  wire logic [7:0]  i_wdata,  // write byte
  input  wire logic [1:0]  i_mode,   // 0 ack 1 fault 2 legacy
  input  wire logic [7:0]  i_delay,  // wait cycles
  output logic             o_ack_n,  // ack
  output logic             o_fault_n,// fault
  output logic             o_sel_n,  // legacy select
  output logic [7:0]       o_rdata,  // read byte
  output logic [7:0]       o_ds_cnt, // data strobes seen
  output logic [7:0]       o_as_cnt  // addr strobes seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] last_q;
  logic [7:0] wait_q;
  logic       ds_q;
  logic       as_q;
  logic       term;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  assign term = !(o_ack_n && o_fault_n && o_sel_n);
  // released bus shows the inverse of its last value so stale data cannot pass
  assign o_rdata = (i_rw && !i_ds_n && term) ? mem[i_addr[7:0]] : ~last_q;
  always @(posedge i_mclk) begin
    last_q <= o_rdata;
    ds_q <= i_ds_n;
    as_q <= i_as_n;
    if (i_rst) begin
      o_ds_cnt <= 8'h00;
      o_as_cnt <= 8'h00;
    end else begin
      o_ds_cnt <= o_ds_cnt + 8'((!i_ds_n && ds_q) ? 1 : 0);
      o_as_cnt <= o_as_cnt + 8'((!i_as_n && as_q) ? 1 : 0);
    end
    if (i_rst || i_ds_n) begin
      wait_q <= 8'h00;
      o_ack_n <= 1'b1;
      o_fault_n <= 1'b1;
      o_sel_n <= 1'b1;
    end else if (wait_q < i_delay) begin
      wait_q <= wait_q + 8'h01;
    end else if (!term) begin
      o_ack_n <= i_mode != 2'h0;
      o_fault_n <= i_mode != 2'h1;
      o_sel_n <= i_mode != 2'h2;
      if (!i_rw && i_mode == 2'h0) mem[i_addr[7:0]] <= i_wdata;
    end
  end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the byte bus sequencer
`default_nettype none
module tb;
  import byte_bus_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              req = 1'b0;
  logic              wr = 1'b0;
  logic              atomic_test_set_op = 1'b0;
  logic [1:0]        sz = 2'h0;
  logic [ADDR_W-1:0] addr = 20'h00000;
  logic [31:0]       wd = 32'h0;
  logic [1:0]        mode = 2'h0;
  logic [7:0]        dly = 8'h00;
  logic [2:0]        fc = 3'h5;
  logic [2:0]        spc;
  logic              ack_n, fault_n, sel_n, busy, done, fault, legacy, rw, as_n, ds_n, doe;
  logic [31:0]       rdata;
  logic [ADDR_W-1:0] pin_addr;
  logic [15:0]       pin_data;
  logic [7:0]        sdata, dsc, asc;
  int                bad_count = 0;
  int                checked = 0;
  always #5 mclk = ~mclk;
  byte_bus_cycle_master i_dut (.i_mclk(mclk), .i_rst(rst), .i_req(req), .i_write(wr),
    .i_atomic_test_set_op(atomic_test_set_op), .i_size(sz), .i_addr(addr), .i_space_code(fc),
    .i_wdata(wd), .i_transfer_ack_n(ack_n), .i_bus_fault_n(fault_n),
    .i_legacy_periph_sel_n(sel_n), .i_data(sdata), .o_busy(busy), .o_done(done),
    .o_fault(fault), .o_legacy(legacy), .o_rdata(rdata), .o_addr(pin_addr), .o_addr_oe(),
    .o_space_code(spc), .o_space_oe(), .o_rw(rw), .o_addr_strobe_n(as_n),
    .o_lower_byte_strobe_n(), .o_data_strobe_n(ds_n), .o_upper_byte_strobe_n(),
    .o_data(pin_data), .o_data_oe(doe));
  byte_bus_slave_model i_slave (.i_mclk(mclk), .i_rst(rst), .i_as_n(as_n), .i_ds_n(ds_n),
    .i_rw(rw), .i_addr(pin_addr), .i_wdata(pin_data[7:0]), .i_mode(mode), .i_delay(dly),
    .o_ack_n(ack_n), .o_fault_n(fault_n), .o_sel_n(sel_n), .o_rdata(sdata),
    .o_ds_cnt(dsc), .o_as_cnt(asc));
  function automatic logic [7:0] exp_b(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction
  task automatic summarize;
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic t, input logic [1:0] s,
                      input logic [19:0] a, input logic [31:0] d, input logic [1:0] m,
                      input logic [7:0] dl);
    int n;
    n = 0;
    @(negedge mclk);
    {wr, atomic_test_set_op, sz, addr, wd, mode, dly} = {w, t, s, a, d, m, dl};
    req = 1'b1;
    while (busy !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    req = 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 3000, 1'b1);
  endtask
  task automatic t_long_read;
    logic [7:0] c;
    c = dsc;
    xfer(1'b0, 1'b0, SIZE_LONG, 20'h00030, 32'h0, 2'h0, 8'h00);
    chk(rdata, {exp_b(8'h30), exp_b(8'h31), exp_b(8'h32), exp_b(8'h33)});
    chk(dsc - c, 32'h4);
    chk(spc, 32'h5);
  endtask
  task automatic t_word_write;
    logic [7:0] c;
    c = dsc;
    fc = 3'h2;
    xfer(1'b1, 1'b0, SIZE_WORD, 20'h00011, 32'h0000BEEF, 2'h0, 8'h02);
    chk(spc, 32'h2);
    chk(i_slave.mem[8'h11], 8'hBE);
    chk(i_slave.mem[8'h12], 8'hEF);
    chk(dsc - c, 32'h2);
  endtask
  task automatic t_atomic;
    logic [7:0] c, ca;
    c = dsc;
    ca = asc;
    // a long size with the atomic flag must still touch a single byte
    xfer(1'b0, 1'b1, SIZE_LONG, 20'h00020, 32'h0, 2'h0, 8'h03);
    chk(rdata[7:0], exp_b(8'h20));
    chk(i_slave.mem[8'h20], exp_b(8'h20) | 8'h80);
    chk(dsc - c, 32'h2);
    chk(asc - ca, 32'h1);
  endtask
  task automatic t_fault;
    xfer(1'b0, 1'b0, SIZE_BYTE, 20'h00040, 32'h0, 2'h1, 8'h01);
    chk(fault, 1'b1);
    chk(legacy, 1'b0);
  endtask
  task automatic t_legacy;
    xfer(1'b1, 1'b0, SIZE_BYTE, 20'h00050, 32'h000000AA, 2'h2, 8'h00);
    chk(legacy, 1'b1);
    chk(i_slave.mem[8'h50], exp_b(8'h50));
  endtask
  task automatic t_byte_read_wait;
    logic [7:0] c;
    c = dsc;
    xfer(1'b0, 1'b0, SIZE_BYTE, 20'h00007, 32'h0, 2'h0, 8'h0C);
    chk(rdata[7:0], exp_b(8'h07));
    chk(dsc - c, 32'h1);
    chk({fault, legacy}, 2'h0);
  endtask
  initial begin
    #50000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    t_long_read();
    t_word_write();
    t_atomic();
    t_fault();
    t_legacy();
    t_byte_read_wait();
    summarize();
  end
endmodule
`default_nettype wire
